/* verilog/datu_defines.vh */
`ifndef DATU_DEFINES_VH
`define DATU_DEFINES_VH
// ************************************************************
// register indices (word addresses on the host port)
// ************************************************************
`define DATU_REG_CTRL 5'h00
`define DATU_REG_TTB 5'h01
`define DATU_REG_TAG 5'h02
`define DATU_REG_DATA 5'h03
`define DATU_REG_INDEX 5'h04
`define DATU_REG_LOAD 5'h05
`define DATU_REG_FSTAT 5'h06
`define DATU_REG_FADDR 5'h07
`define DATU_REG_FACK 5'h08
`define DATU_REG_RTAG 5'h09
`define DATU_REG_RDATA 5'h0a
// ************************************************************
// control fields
// ************************************************************
`define DATU_CTRL_EN 0
`define DATU_CTRL_WALK 1
`define DATU_CTRL_RST 2'h0
// ************************************************************
// page size codes
// ************************************************************
`define DATU_PS_SECT 2'h0
`define DATU_PS_LARGE 2'h1
`define DATU_PS_SMALL 2'h2
`define DATU_PS_TINY 2'h3
// ************************************************************
// fault status codes
// ************************************************************
`define DATU_F_MISS 3'h1
`define DATU_F_TRANS 3'h2
`define DATU_F_PERM 3'h4
// ************************************************************
// passthrough window base: first 16 mbyte of cs0
// ************************************************************
`define DATU_CS0_BASE 8'h00
`endif

/* verilog/datu_tlb.v */
`timescale 1ns/1ps
`include "datu_defines.vh"
// tag fields: {size[1:0], valid, preserve, tag[23:10]}
// data fields: {ap[1:0], phys[31:10]}
module datu_tlb #(
	parameter ENTRIES = 32,
	parameter IW = 5
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [23:0] lookup_addr_i,
	output reg hit_o,
	output reg [31:0] phys_o,
	output reg [1:0] ap_o,
	input wire wr_i,
	input wire [IW-1:0] wr_idx_i,
	input wire [17:0] wr_tag_i,
	input wire [23:0] wr_data_i,
	input wire [IW-1:0] rd_idx_i,
	output wire [17:0] rd_tag_o,
	output wire [23:0] rd_data_o
);
	reg [17:0] tag_q [0:ENTRIES-1];
	reg [23:0] data_q [0:ENTRIES-1];
	integer i;
	integer j;

	// ************************************************************
	// boundary of translated bits for a size code
	// ************************************************************
	function [13:0] size_mask;
		input [1:0] ps;
		begin
			case (ps)
			`DATU_PS_SECT: size_mask = 14'h3c00;
			`DATU_PS_LARGE: size_mask = 14'h3fc0;
			`DATU_PS_SMALL: size_mask = 14'h3ffc;
			default: size_mask = 14'h3fff;
			endcase
		end
	endfunction

	function [31:0] join_addr;
		input [1:0] ps;
		input [21:0] hi;
		input [23:0] la;
		reg [21:0] m;
		begin
			m = {8'hff, size_mask(ps)};
			join_addr = {(hi & m) | ({8'h00, la[23:10]} & ~m), la[9:0]}; // R5
		end
	endfunction

	// ************************************************************
	// parallel search, last match wins
	// ************************************************************
	always @* begin
		hit_o = 1'b0;
		phys_o = 32'h0;
		ap_o = 2'h0;
		for (i = 0; i < ENTRIES; i = i + 1) begin
			if (tag_q[i][15] && ((tag_q[i][13:0] ^ lookup_addr_i[23:10]) &
				size_mask(tag_q[i][17:16])) == 14'h0) begin // R4
				hit_o = 1'b1;
				phys_o = join_addr(tag_q[i][17:16], data_q[i][21:0],
					lookup_addr_i);
				ap_o = data_q[i][23:22];
			end
		end
	end

	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (j = 0; j < ENTRIES; j = j + 1) begin
				tag_q[j] <= 18'h0; // R2
				data_q[j] <= 24'h0;
			end
		end else if (wr_i) begin
			tag_q[wr_idx_i] <= wr_tag_i; // R6
			data_q[wr_idx_i] <= wr_data_i; // R7
		end
	end

	assign rd_tag_o = tag_q[rd_idx_i];
	assign rd_data_o = data_q[rd_idx_i];
endmodule // datu_tlb

/* verilog/datu_top.v */
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "datu_defines.vh"
// Summary of operation
// R1: maps 24-bit dsp external addresses to 32-bit physical addresses.
// R2: after reset disabled; dsp window maps to first 16 mbyte of cs0.
// R3: buffer holds 32 entries of 1m, 64k, 4k or 1k pages.
// R4: page size and upper logical bits search tags; hit gives upper bits.
// R5: physical = upper buffer bits joined with unchanged low logical bits.
// R6: tag entry keeps tag, preserve flag, valid flag and size code.
// R7: data entry keeps upper physical bits and permission field.
// R8: disabled unit passes addresses through, no checks, no walks.
// R9: host reaches tag/data stores only while walking is disabled.
// R10: on a miss with walking enabled, unit walks page table itself.
// R11: every fault raises the dedicated fault interrupt line.
// R12: internal dsp memory accesses bypass translation and checks.
// R13: whole unit runs on the traffic controller clock.
// R14: host programs registers through the peripheral bus bridge.
// R15: host should load entries before enabling translation.
// R16: first-level code 00 is fault, 01 is coarse table base.
// R17: permission 0x no access, 10 read only, 11 read and write.
// R18: second-level codes: fault, large, small, tiny page ascending.
// R19: walked translation replaces a randomly chosen buffer line.
// R20: on fault the request stalls until host writes the acknowledge.
// R21: during a walk the request waits, then completes with new entry.
module datu_top #(
	parameter ENTRIES = 32, // R3
	parameter IW = 5
) (
	input wire sys_clk_i, // R13
	input wire rst_n_i,
	// host register port
	input wire [4:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	output wire fault_irq_o,
	// dsp request side
	input wire dsp_req_i,
	input wire dsp_we_i,
	input wire dsp_internal_i,
	input wire [23:0] dsp_addr_i,
	output wire dsp_ack_o,
	// system memory side
	output wire mem_req_o,
	output wire mem_we_o,
	output wire [31:0] mem_addr_o,
	input wire mem_ack_i,
	input wire [31:0] mem_rdata_i,
	input wire mem_rvalid_i
);
	localparam S_IDLE = 6'h01;
	localparam S_L1 = 6'h02;
	localparam S_L2 = 6'h04;
	localparam S_FILL = 6'h08;
	localparam S_FAULT = 6'h10;
	localparam S_ACC = 6'h20;

	reg [1:0] ctrl_q;
	reg [31:0] ttb_q;
	reg [17:0] wtag_q;
	reg [23:0] wdata_q;
	reg [IW-1:0] idx_q;
	reg [2:0] fstat_q;
	reg [23:0] faddr_q;
	reg [5:0] state_q;
	reg [5:0] state_d;
	reg [31:0] l1_q;
	reg [17:0] ftag_q;
	reg [23:0] fdata_q;
	reg [7:0] lfsr_q;
	reg [31:0] rd_d;
	reg fault_set;
	reg [2:0] fault_code;
	reg walk_wr;
	reg [31:0] walk_addr;
	reg rd_issued_q;
	wire en;
	wire walk_en;
	wire hit;
	wire [31:0] tlb_phys;
	wire [1:0] tlb_ap;
	wire [17:0] rd_tag;
	wire [23:0] rd_data;
	wire tlb_wr;
	wire host_load;
	wire perm_ok;
	wire bypass;
	wire [31:0] pass_addr;
	wire [IW-1:0] wr_idx;
	wire fack_wr;
	wire walking;

	assign en = ctrl_q[`DATU_CTRL_EN];
	assign walk_en = ctrl_q[`DATU_CTRL_WALK];
	// internal accesses never see the buffer or the walker
	assign bypass = dsp_internal_i | !en; // R8 R12
	assign pass_addr = {`DATU_CS0_BASE, dsp_addr_i}; // R2
	assign fack_wr = reg_wr_i && reg_addr_i == `DATU_REG_FACK;
	assign walking = state_q == S_L1 || state_q == S_L2;

	// ************************************************************
	// permission decode
	// ************************************************************
	function perm_check;
		input [1:0] ap;
		input we;
		begin
			perm_check = ap[1] & (ap[0] | !we); // R17
		end
	endfunction

	assign perm_ok = perm_check(tlb_ap, dsp_we_i);

	// ************************************************************
	// translation buffer
	// ************************************************************
	// loads refused while the walker owns the buffer
	assign host_load = reg_wr_i && reg_addr_i == `DATU_REG_LOAD &&
		!walk_en && reg_wdata_i[0]; // R9
	assign tlb_wr = host_load | walk_wr;
	// random victim so no line starves under repeated misses
	assign wr_idx = walk_wr ? lfsr_q[IW-1:0] : idx_q; // R19

	datu_tlb #(.ENTRIES(ENTRIES), .IW(IW)) u_tlb (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.lookup_addr_i(dsp_addr_i), // R1
		.hit_o(hit),
		.phys_o(tlb_phys),
		.ap_o(tlb_ap),
		.wr_i(tlb_wr),
		.wr_idx_i(wr_idx),
		.wr_tag_i(walk_wr ? ftag_q : wtag_q),
		.wr_data_i(walk_wr ? fdata_q : wdata_q),
		.rd_idx_i(idx_q),
		.rd_tag_o(rd_tag),
		.rd_data_o(rd_data)
	);

	// ************************************************************
	// request path
	// ************************************************************
	wire xlate_ok;
	assign xlate_ok = state_q == S_IDLE && hit && perm_ok;
	wire walk_req;
	assign walk_req = walking && !rd_issued_q;
	assign mem_req_o = dsp_req_i && (bypass ? state_q == S_IDLE :
		xlate_ok || walk_req);
	assign mem_we_o = state_q == S_IDLE ? dsp_we_i : 1'b0;
	assign mem_addr_o = walking ? walk_addr :
		(bypass ? pass_addr : tlb_phys);
	// ack only while the request still stands
	assign dsp_ack_o = dsp_req_i && state_q == S_IDLE && mem_ack_i &&
		(bypass || xlate_ok); // R21
	// level output: stays until the host acknowledges
	assign fault_irq_o = state_q == S_FAULT; // R11

	always @* begin
		walk_addr = 32'h0;
		// first level: one word per mbyte of dsp space
		if (state_q == S_L1)
			walk_addr = {ttb_q[31:14], 8'h00, dsp_addr_i[23:20], 2'h0};
		// second level: coarse table, one word per 4 kbyte page
		else if (state_q == S_L2)
			walk_addr = {l1_q[31:10], dsp_addr_i[19:12], 2'h0};
	end

	always @* begin
		state_d = state_q;
		fault_set = 1'b0;
		fault_code = 3'h0;
		walk_wr = 1'b0;
		case (state_q)
		S_IDLE: begin
			if (dsp_req_i && !bypass) begin
				if (!hit && walk_en) begin
					state_d = S_L1; // R10
				end else if (!hit) begin
					fault_set = 1'b1;
					fault_code = `DATU_F_MISS;
				end else if (!perm_ok) begin
					fault_set = 1'b1;
					fault_code = `DATU_F_PERM;
				end
				if (fault_set)
					state_d = S_FAULT; // R20
			end
		end
		S_L1: begin
			if (mem_rvalid_i) begin
				if (mem_rdata_i[1:0] == 2'h1) begin // R16
					state_d = S_L2;
				end else begin
					fault_set = 1'b1;
					fault_code = `DATU_F_TRANS;
					state_d = S_FAULT;
				end
			end
		end
		S_L2: begin
			if (mem_rvalid_i) begin
				if (mem_rdata_i[1:0] == 2'h0) begin // R18
					fault_set = 1'b1;
					fault_code = `DATU_F_TRANS;
					state_d = S_FAULT;
				end else begin
					state_d = S_FILL;
				end
			end
		end
		S_FILL: begin
			walk_wr = 1'b1; // R21
			state_d = S_IDLE;
		end
		S_FAULT: begin
			if (fack_wr)
				state_d = S_IDLE; // R20
		end
		default: state_d = S_IDLE;
		endcase
	end

	// ************************************************************
	// walker state and victim choice
	// ************************************************************
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			state_q <= S_IDLE;
		else
			state_q <= state_d;
	end

	// free running, so the victim does not track the miss pattern
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			lfsr_q <= 8'h01;
		else
			lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^
				lfsr_q[4] ^ lfsr_q[3]};
	end

	// one read per level: the request drops once memory has taken it
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rd_issued_q <= 1'b0;
		else if (state_q != state_d)
			rd_issued_q <= 1'b0;
		else if (mem_req_o && mem_ack_i && state_q != S_IDLE)
			rd_issued_q <= 1'b1;
	end

	// ************************************************************
	// descriptor capture
	// ************************************************************
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			l1_q <= 32'h0;
		else if (state_q == S_L1 && mem_rvalid_i)
			l1_q <= mem_rdata_i;
	end

	// new entry: size code is the second-level type, valid, not preserved
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ftag_q <= 18'h0;
			fdata_q <= 24'h0;
		end else if (state_q == S_L2 && mem_rvalid_i) begin
			ftag_q <= {mem_rdata_i[1:0], 1'b1, 1'b0,
				dsp_addr_i[23:10]}; // R18
			fdata_q <= {mem_rdata_i[5:4], mem_rdata_i[31:10]};
		end
	end

	// ************************************************************
	// fault status: a new fault beats a same-cycle acknowledge
	// ************************************************************
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fstat_q <= 3'h0;
			faddr_q <= 24'h0;
		end else if (fault_set) begin
			fstat_q <= fault_code;
			faddr_q <= dsp_addr_i;
		end else if (fack_wr) begin
			fstat_q <= 3'h0;
		end
	end

	// ************************************************************
	// host registers
	// ************************************************************
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= `DATU_CTRL_RST; // R2
			ttb_q <= 32'h0;
			wtag_q <= 18'h0;
			wdata_q <= 24'h0;
			idx_q <= {IW{1'b0}};
			reg_rdata_o <= 32'h0;
		end else begin
			if (reg_wr_i) begin // R14
				if (reg_addr_i == `DATU_REG_CTRL)
					ctrl_q <= reg_wdata_i[1:0];
				else if (reg_addr_i == `DATU_REG_TTB)
					ttb_q <= {reg_wdata_i[31:14], 14'h0};
				else if (reg_addr_i == `DATU_REG_TAG)
					wtag_q <= reg_wdata_i[17:0];
				else if (reg_addr_i == `DATU_REG_DATA)
					wdata_q <= reg_wdata_i[23:0];
				else if (reg_addr_i == `DATU_REG_INDEX)
					idx_q <= reg_wdata_i[IW-1:0];
			end
			reg_rdata_o <= reg_rd_i ? rd_d : 32'h0;
		end
	end

	// ************************************************************
	// register read-back
	// ************************************************************
	always @* begin
		rd_d = 32'h0;
		if (reg_addr_i == `DATU_REG_CTRL)
			rd_d = {30'h0, ctrl_q};
		else if (reg_addr_i == `DATU_REG_TTB)
			rd_d = ttb_q;
		else if (reg_addr_i == `DATU_REG_TAG)
			rd_d = {14'h0, wtag_q};
		else if (reg_addr_i == `DATU_REG_DATA)
			rd_d = {8'h0, wdata_q};
		else if (reg_addr_i == `DATU_REG_INDEX)
			rd_d = {{(32-IW){1'b0}}, idx_q};
		else if (reg_addr_i == `DATU_REG_FSTAT)
			rd_d = {29'h0, fstat_q};
		else if (reg_addr_i == `DATU_REG_FADDR)
			rd_d = {8'h0, faddr_q};
		else if (reg_addr_i == `DATU_REG_RTAG && !walk_en)
			rd_d = {14'h0, rd_tag}; // R9
		else if (reg_addr_i == `DATU_REG_RDATA && !walk_en)
			rd_d = {8'h0, rd_data}; // R9
	end
endmodule // datu_top

/* dv/datu_top_sva.sv */
`timescale 1ns/1ps
module datu_top_sva #(
	parameter ENTRIES = 32,
	parameter IW = 5
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [4:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [31:0] reg_rdata_o,
	input wire fault_irq_o,
	input wire dsp_req_i,
	input wire dsp_internal_i,
	input wire [23:0] dsp_addr_i,
	input wire dsp_ack_o,
	input wire mem_req_o,
	input wire [31:0] mem_addr_o,
	input wire mem_ack_i
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// shadow of the control bits, seen only through host writes
	reg en_q;
	reg walk_q;
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_q <= 1'b0;
			walk_q <= 1'b0;
		end else if (reg_wr_i && reg_addr_i == 5'h00) begin
			en_q <= reg_wdata_i[0];
			walk_q <= reg_wdata_i[1];
		end
	end
	a_ack_from_mem: assert property (dsp_ack_o |-> mem_ack_i && dsp_req_i)
		else $error("dsp ack without memory ack");
	a_pass_disabled: assert property (dsp_req_i && !en_q && mem_req_o
		|-> mem_addr_o == {8'h00, dsp_addr_i})
		else $error("disabled unit altered address");
	a_pass_internal: assert property (dsp_req_i && dsp_internal_i &&
		mem_req_o |-> mem_addr_o == {8'h00, dsp_addr_i})
		else $error("internal access translated");
	a_no_walk_off: assert property (dsp_req_i && !en_q && !fault_irq_o
		|-> mem_req_o && mem_addr_o == {8'h00, dsp_addr_i})
		else $error("disabled unit held or redirected a request");
	a_irq_stall: assert property (fault_irq_o |-> !dsp_ack_o)
		else $error("request completed during fault");
	a_irq_hold: assert property (fault_irq_o &&
		!(reg_wr_i && reg_addr_i == 5'h08) |=> fault_irq_o)
		else $error("fault dropped without acknowledge");
	a_irq_cause: assert property ($rose(fault_irq_o)
		|-> en_q && $past(dsp_req_i))
		else $error("fault without enabled request");
	a_store_lock: assert property (walk_q && reg_rd_i &&
		(reg_addr_i == 5'h09 || reg_addr_i == 5'h0a) |=> reg_rdata_o == 0)
		else $error("store readable while walking");
	a_rdata_pulse: assert property (reg_rdata_o != 32'h0
		|-> $past(reg_rd_i))
		else $error("read data outside read slot");
	a_req_hold: assert property (mem_req_o && !mem_ack_i && en_q &&
		!fault_irq_o |=> mem_req_o)
		else $error("memory request withdrawn before ack");
endmodule // datu_top_sva
bind datu_top datu_top_sva #(.ENTRIES(ENTRIES), .IW(IW)) i_datu_top_sva (
	.sys_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
	.reg_rdata_o, .fault_irq_o, .dsp_req_i, .dsp_internal_i, .dsp_addr_i,
	.dsp_ack_o, .mem_req_o, .mem_addr_o, .mem_ack_i);

/* dv/datu_mem_model.sv */
`timescale 1ns/1ps
module datu_mem_model (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire slow_i,
	input wire req_i,
	input wire we_i,
	input wire [31:0] addr_i,
	output reg ack_o,
	output reg [31:0] rdata_o,
	output reg rvalid_o
);
	// page table words: ttb area and one coarse table
	reg [31:0] mem [0:31];
	reg [1:0] wait_q;
	integer k;
	initial for (k = 0; k < 32; k = k + 1) mem[k] = 32'h0;
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'b0;
			rvalid_o <= 1'b0;
			rdata_o <= 32'h0;
			wait_q <= 2'h0;
		end else begin
			ack_o <= 1'b0;
			rvalid_o <= 1'b0;
			// released bus keeps moving so stale data never looks valid
			rdata_o <= ~rdata_o;
			if (req_i && !ack_o) begin
				if (wait_q >= {slow_i, slow_i}) begin
					ack_o <= 1'b1;
					wait_q <= 2'h0;
				end else
					wait_q <= wait_q + 2'h1;
			end
			if (ack_o && !we_i) begin
				rvalid_o <= 1'b1;
				rdata_o <= mem[{addr_i[21], addr_i[5:2]}];
			end
		end
	end
endmodule // datu_mem_model

/* dv/datu_top_tb.sv */
`timescale 1ns/1ps
module datu_top_tb;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg [4:0] reg_addr = 5'h0;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg dsp_req = 1'b0;
	reg dsp_we = 1'b0;
	reg dsp_int = 1'b0;
	reg [23:0] dsp_addr = 24'h0;
	reg slow = 1'b0;
	wire [31:0] rdata;
	wire irq;
	wire dsp_ack;
	wire mem_req;
	wire mem_we;
	wire [31:0] mem_addr;
	wire mem_ack;
	wire [31:0] mem_rdata;
	wire mem_rvalid;
	integer n_errors = 0;
	integer total_checks = 0;
	initial forever #10 clk = ~clk;
	datu_top i_datu_top (.sys_clk_i(clk), .rst_n_i(rst_n),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd), .reg_rdata_o(rdata), .fault_irq_o(irq),
		.dsp_req_i(dsp_req), .dsp_we_i(dsp_we), .dsp_internal_i(dsp_int),
		.dsp_addr_i(dsp_addr), .dsp_ack_o(dsp_ack), .mem_req_o(mem_req),
		.mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_ack_i(mem_ack),
		.mem_rdata_i(mem_rdata), .mem_rvalid_i(mem_rvalid));
	datu_mem_model i_mem (.sys_clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
		.req_i(mem_req), .we_i(mem_we), .addr_i(mem_addr), .ack_o(mem_ack),
		.rdata_o(mem_rdata), .rvalid_o(mem_rvalid));
	// ************************************************************
	// shared tasks
	// ************************************************************
	task results;
		begin
			$display("errors %0d checks %0d", n_errors, total_checks);
			if (n_errors == 0 && total_checks > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("[FAIL] %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task wr(input [4:0] a, input [31:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
			#1;
		end
	endtask
	task rd(input [4:0] a, input [31:0] e);
		begin
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1;
			chk(rdata, e);
		end
	endtask
	task ld(input [4:0] i, input [23:0] a, input v, input [1:0] ap);
		begin
			wr(5'h04, {27'h0, i});
			wr(5'h02, {14'h0, 2'h0, v, 1'b0, a[23:10]});
			wr(5'h03, {8'h0, ap, 22'h130c00});
			wr(5'h05, 32'h1);
		end
	endtask
	// fault expected when fs is not zero; request then stays pending
	task dsp(input [23:0] a, input we, input it, input [31:0] e,
		input [2:0] fs);
		integer n;
		begin
			n = 0;
			dsp_addr <= a;
			dsp_we <= we;
			dsp_int <= it;
			dsp_req <= 1'b1;
			@(negedge clk);
			while (dsp_ack !== 1'b1 && irq !== 1'b1 && n < 300) begin
				@(negedge clk);
				n = n + 1;
			end
			if (n == 300) begin
				n_errors = n_errors + 1;
				results;
			end
			chk({31'h0, irq}, {31'h0, fs != 3'h0});
			if (fs == 3'h0) begin
				chk(mem_addr, e);
				chk({30'h0, mem_req, mem_we}, {30'h0, 1'b1, we});
			end
			@(posedge clk);
			if (fs == 3'h0)
				dsp_req <= 1'b0;
			#1;
			if (fs != 3'h0) begin
				rd(5'h06, {29'h0, fs});
				rd(5'h07, {8'h0, a});
			end
		end
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task t_fault(input [23:0] a, input v, input [1:0] ap, input we,
		input [2:0] fs);
		begin
			ld(5'h01, a, v, ap);
			dsp(a, we, 1'b0, 32'h0, fs);
			ld(5'h01, a, 1'b1, 2'h3);
			wr(5'h08, 32'h1);
			dsp(a, we, 1'b0, {12'h4c3, a[19:0]}, 3'h0);
		end
	endtask
	task t_wfault(input [23:0] a, input [4:0] k, input [31:0] d);
		begin
			dsp(a, 1'b0, 1'b0, 32'h0, 3'h2);
			i_mem.mem[k] = d;
			wr(5'h08, 32'h1);
			dsp(a, 1'b0, 1'b0, 32'h6b7de234, 3'h0);
		end
	endtask
	task t_walk;
		integer k;
		begin
			for (k = 8; k < 12; k = k + 1)
				i_mem.mem[k] = 32'h00200001;
			i_mem.mem[17] = 32'h7a5c0031;
			i_mem.mem[18] = 32'h6b7de032;
			i_mem.mem[19] = 32'h5c8e1c33;
			i_mem.mem[21] = 32'h6b7de032;
			slow <= 1'b1;
			wr(5'h01, 32'h00100000);
			wr(5'h00, 32'h3);
			rd(5'h09, 32'h0);
			dsp(24'h801234, 1'b0, 1'b0, 32'h7a5c1234, 3'h0);
			dsp(24'h902234, 1'b0, 1'b0, 32'h6b7de234, 3'h0);
			dsp(24'ha03234, 1'b0, 1'b0, 32'h5c8e1e34, 3'h0);
			t_wfault(24'hb04234, 5'd20, 32'h6b7de032);
			t_wfault(24'hc05234, 5'd12, 32'h00200001);
		end
	endtask
	task t_reset_pass;
		begin
			rd(5'h00, 32'h0);
			rd(5'h1f, 32'h0);
			dsp(24'habcdef, 1'b0, 1'b0, 32'h00abcdef, 3'h0);
		end
	endtask
	task t_load;
		begin
			ld(5'h1f, 24'h345678, 1'b1, 2'h3);
			rd(5'h09, {14'h0, 4'h2, 14'hd15});
			rd(5'h0a, {8'h0, 2'h3, 22'h130c00});
			wr(5'h00, 32'h1);
			dsp(24'h345678, 1'b1, 1'b0, 32'h4c345678, 3'h0);
			dsp(24'h345678, 1'b1, 1'b1, 32'h00345678, 3'h0);
		end
	endtask
	task t_perm;
		begin
			t_fault(24'h6abcde, 1'b0, 2'h3, 1'b0, 3'h1);
			t_fault(24'h6abcde, 1'b1, 2'h2, 1'b1, 3'h4);
			t_fault(24'h6abcde, 1'b1, 2'h1, 1'b0, 3'h4);
			dsp(24'h6abcde, 1'b0, 1'b0, 32'h4c3abcde, 3'h0);
		end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		t_reset_pass;
		t_load;
		t_perm;
		t_walk;
		results;
	end
endmodule // datu_top_tb
